// ==== shared/pci_port_pkg.sv ====
// Shared constants for the PCI host port device end, host end and link
package pci_port_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_NS    = 5;
  localparam int PCLK_PERIOD_NS = 120;
  localparam int PCLK_HALF      = PCLK_PERIOD_NS / (2 * CORE_CLK_NS);
  localparam int DIV_W          = 5;

  // ----------------------------------------------------------------
  // Link commands and host-visible map
  // ----------------------------------------------------------------
  localparam logic [1:0]  CMD_REG_WR    = 2'h0;
  localparam logic [1:0]  CMD_REG_RD    = 2'h1;
  localparam logic [1:0]  CMD_MEM_WR    = 2'h2;
  localparam logic [1:0]  CMD_MEM_RD    = 2'h3;
  localparam logic [31:0] WINDOW_BASE   = 32'h0001_0000;
  localparam int          WINDOW_WORDS  = 16377;
  localparam logic [31:0] WINDOW_LIMIT  = WINDOW_BASE + 32'(WINDOW_WORDS * 4);
  localparam logic [3:0]  HREG_CTRL     = 4'h0;
  localparam logic [3:0]  HREG_STAT     = 4'h4;
  localparam logic [3:0]  HREG_CVR      = 4'h8;
  localparam int          HC_TXF_LSB    = 0;
  localparam int          HC_RXF_LSB    = 2;
  localparam int          HC_FLAGS_LSB  = 4;
  localparam int          HS_HOST_TX_READY_FLAG_BIT   = 0;
  localparam int          HS_FLAGS_LSB  = 1;
  localparam int          HS_PSR_BIT    = 4;
  localparam int          CV_NMI_BIT    = 7;
  localparam int          VEC_W         = 7;
  localparam logic [6:0]  RST_HCTRL     = 7'h00;

  // ----------------------------------------------------------------
  // Core-side register map
  // ----------------------------------------------------------------
  localparam int          CREG_AW       = 8;
  localparam logic [7:0]  CREG_CTRL     = 8'h00;
  localparam logic [7:0]  CREG_PCTRL    = 8'h04;
  localparam logic [7:0]  CREG_MCTRL    = 8'h08;
  localparam logic [7:0]  CREG_STAT     = 8'h0C;
  localparam logic [7:0]  CREG_RXOUT    = 8'h10;
  localparam logic [7:0]  CREG_IRQ_ST   = 8'h14;
  localparam logic [7:0]  CREG_IRQ_MSK  = 8'h18;
  localparam logic [7:0]  CREG_CVR      = 8'h1C;
  localparam logic [7:0]  CREG_TXWORD   = 8'h20;
  localparam int          DC_MODE_LSB   = 0;
  localparam int          DC_HOST_IRQ_SET_BIT_BIT   = 3;
  localparam int          DC_FLAGS_LSB  = 4;
  localparam int          DC_COMMAND_IRQ_ENABLE_BIT   = 7;
  localparam int          PC_IAE_BIT    = 0;
  localparam int          MC_FC_LSB     = 0;
  localparam int          CS_ACT_BIT    = 0;
  localparam int          CS_FLAGS_LSB  = 1;
  localparam int          CS_RXNE_BIT   = 4;
  localparam int          CS_LOCK_BIT   = 5;
  localparam logic [7:0]  RST_DCTRL     = 8'h00;
  localparam int          IRQ_HCMD      = 0;
  localparam int          IRQ_RX        = 1;
  localparam int          IRQ_RETRY     = 2;
  localparam int          IRQ_W         = 3;

  // ----------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------
  localparam int          CORE_W        = 24;
  localparam int          RXQ_DEPTH     = 6;
  localparam logic [1:0]  FMT_32        = 2'h0;
  localparam logic [1:0]  FMT_LEFT      = 2'h2;
  localparam logic [1:0]  FMT_SIGN      = 2'h3;
endpackage : pci_port_pkg

// ==== shared/pci_link_if.sv ====
// Link between the host end and the device end of the PCI port
`timescale 1ns/1ps
interface pci_link_if;
  logic        pclk;
  logic        frame_n;
  logic        lock_n;
  logic [1:0]  cmd;
  logic [31:0] ad;
  logic [31:0] rdata;
  logic        retry;
  logic        irq_n_o;
  logic        irq_n_oe;
  logic        irq_n;

  // Open-drain interrupt line, pulled up when nobody drives it
  assign irq_n = irq_n_oe ? irq_n_o : 1'b1;

  modport dev  (input pclk, frame_n, lock_n, cmd, ad, output rdata, retry, irq_n_o, irq_n_oe);
  modport host (output pclk, frame_n, lock_n, cmd, ad, input rdata, retry, irq_n);
endinterface : pci_link_if

// ==== verilog/sync2.sv ====
// Two-flop synchroniser for levels entering the core clock domain
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] init,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // Init is a tie-off constant, used only for the released value
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d ^ init;
      q      <= meta_r ^ init;
    end
  end
endmodule : sync2

// ==== verilog/pci_port_dev.sv ====
// Device end of the PCI host port: window decode, formats, commands, flags, lock
// ------------------------------------------------------------------
// How it works
// - Whole window writes feed one receive queue
// - Insert start address ahead of data words
// - Insertion enabled by port control register bit
// - Convert between 32-bit link and 24-bit core
// - Master format field in master control register
// - Host selects slave transmit and receive formats
// - Host changes slave formats only in soft reset
// - Clear mode starts reset; active flag reports
// - Host interrupt bit drives active-low pin
// - Core changes master format only in soft reset
// - Command vector write raises core interrupt
// - Non-maskable command bypasses enable and mask
// - Host-to-core flags: host writes, core reads
// - Core-to-host flags: core writes, host reads
// - Host reads transmit-ready status bit
// - Master locks only after seeing lock free
// - Owner drops lock in address phase
// - Lock held whole burst gets retry
// ------------------------------------------------------------------
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
module pci_port_dev (
  input  wire logic                             core_clk,
  input  wire logic                             rst_n,
  pci_link_if.dev                               link,
  input  wire logic [pci_port_pkg::CREG_AW-1:0] reg_addr,
  input  wire logic [31:0]                      reg_wdata,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_rd,
  output logic      [31:0]                      reg_rdata,
  output logic                                  core_irq,
  output logic                                  cmd_nmi,
  output logic      [pci_port_pkg::VEC_W-1:0]   cmd_vector,
  output logic      [1:0]                       master_format
);
  import pci_port_pkg::*;

  // ----------------------------------------------------------------
  // Link sampling
  // ----------------------------------------------------------------
  logic        s_pclk, s_frame_n, s_lock_n;
  logic [1:0]  s_cmd;
  logic [31:0] s_ad;
  logic        pclk_d_r;
  logic        edge_w;

  sync2 #(.W(37)) u_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .d     ({link.pclk, link.frame_n, link.lock_n, link.cmd, link.ad}),
    .init  ({3'b011, 34'h0_0000_0000}),
    .q     ({s_pclk, s_frame_n, s_lock_n, s_cmd, s_ad})
  );

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pclk_d_r <= 1'b0;
    else
      pclk_d_r <= s_pclk;
  end

  assign edge_w = s_pclk & ~pclk_d_r;

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  logic [6:0]         hctrl_r;
  logic [7:0]         dctrl_r;
  logic               iae_r;
  logic [IRQ_W-1:0]   irq_st_r, irq_msk_r, irq_set;
  logic [CORE_W-1:0]  tx_word_r;
  logic               tx_valid_r;
  logic               in_burst_r, retry_r, locked_r, lock_addr_n_r;
  logic [1:0]         cmd_r;
  logic [31:0]        addr_r, rdata_r;
  logic [CORE_W-1:0]  q_mem [RXQ_DEPTH];
  logic [2:0]         wr_ptr_r, rd_ptr_r, count_r;
  logic [CORE_W-1:0]  pend_r [2];
  logic [1:0]         pend_n_r;
  logic               addr_ph, data_ph, end_ph, hit, active, soft_reset_state, push, pop, addr_ok;
  logic [1:0]         txf, n_words, n_ins;
  logic [2:0]         free;
  logic [31:0]        tx_fmt, host_rd;

  assign txf     = hctrl_r[HC_TXF_LSB +: 2];
  assign addr_ph = edge_w & ~s_frame_n & ~in_burst_r;
  assign data_ph = edge_w & ~s_frame_n & in_burst_r & ~retry_r;
  assign end_ph  = edge_w & s_frame_n & in_burst_r;
  assign hit     = (s_ad >= WINDOW_BASE) && (s_ad < WINDOW_LIMIT);
  assign active  = (dctrl_r[DC_MODE_LSB +: 3] != 3'h0) || in_burst_r || (pend_n_r != 2'h0);
  assign soft_reset_state     = ~active;
  assign n_words = (txf == FMT_32) ? 2'h2 : 2'h1;
  assign n_ins   = iae_r ? n_words : 2'h0;
  assign free    = 3'(RXQ_DEPTH) - count_r;
  assign push    = pend_n_r != 2'h0;
  assign pop     = reg_rd && reg_addr == CREG_RXOUT && count_r != 3'h0;
  // A retried address phase must leave nothing in the queue
  assign addr_ok = !(locked_r && !s_lock_n) && (dctrl_r[DC_MODE_LSB +: 3] != 3'h0) && hit
                   && (free >= ({1'b0, n_ins} + {1'b0, n_words}));

  always_comb
  begin
    case (hctrl_r[HC_RXF_LSB +: 2])
      FMT_LEFT: tx_fmt = {tx_word_r, 8'h00};
      FMT_SIGN: tx_fmt = {{8{tx_word_r[CORE_W-1]}}, tx_word_r};
      default:  tx_fmt = {8'h00, tx_word_r};
    endcase
    case (s_ad[3:0])
      HREG_CTRL: host_rd = {25'h000_0000, hctrl_r};
      HREG_STAT: host_rd = {27'h000_0000, soft_reset_state, dctrl_r[DC_FLAGS_LSB +: 3],
                            count_r < 3'(RXQ_DEPTH)};
      HREG_CVR:  host_rd = {25'h000_0000, cmd_vector};
      default:   host_rd = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Transaction tracking, retry and lock
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_burst_r    <= 1'b0;
      retry_r       <= 1'b0;
      cmd_r         <= CMD_REG_WR;
      addr_r        <= 32'h0000_0000;
      rdata_r       <= 32'h0000_0000;
      lock_addr_n_r <= 1'b1;
    end
    else if (addr_ph)
    begin
      in_burst_r    <= 1'b1;
      cmd_r         <= s_cmd;
      addr_r        <= s_ad;
      lock_addr_n_r <= s_lock_n;
      rdata_r       <= (s_cmd == CMD_MEM_RD) ? tx_fmt : host_rd;
      if (locked_r && !s_lock_n)
        retry_r <= 1'b1;
      else if (s_cmd[1] && (dctrl_r[DC_MODE_LSB +: 3] == 3'h0 || !hit))
        retry_r <= 1'b1;
      else if (s_cmd == CMD_MEM_WR)
        retry_r <= free < ({1'b0, n_ins} + {1'b0, n_words});
      else if (s_cmd == CMD_MEM_RD)
        retry_r <= ~tx_valid_r;
      else
        retry_r <= 1'b0;
    end
    else if (data_ph && cmd_r == CMD_MEM_WR)
      retry_r <= (free - {1'b0, n_words}) < {1'b0, n_words};
    else if (data_ph && cmd_r != CMD_MEM_WR)
      retry_r <= 1'b1;
    else if (end_ph)
    begin
      in_burst_r <= 1'b0;
      retry_r    <= 1'b0;
    end
  end

  // Owner shows lock free at address, taken in data
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      locked_r <= 1'b0;
    else if (data_ph && lock_addr_n_r && !s_lock_n)
      locked_r <= 1'b1;
    else if (edge_w && s_frame_n && s_lock_n)
      locked_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Receive queue
  // ----------------------------------------------------------------
  // Pushes are spread over core cycles; link phases are far apart
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_n_r  <= 2'h0;
      pend_r[0] <= '0;
      pend_r[1] <= '0;
    end
    else if (addr_ph && s_cmd == CMD_MEM_WR && iae_r && addr_ok)
    begin
      pend_n_r  <= n_words;
      pend_r[0] <= (txf == FMT_32) ? {8'h00, s_ad[15:0]} : s_ad[CORE_W-1:0];
      pend_r[1] <= {8'h00, s_ad[31:16]};
    end
    else if (data_ph && cmd_r == CMD_MEM_WR)
    begin
      pend_n_r <= n_words;
      case (txf)
        FMT_32:   pend_r[0] <= {8'h00, s_ad[15:0]};
        FMT_LEFT: pend_r[0] <= s_ad[31:8];
        default:  pend_r[0] <= s_ad[CORE_W-1:0];
      endcase
      pend_r[1] <= {8'h00, s_ad[31:16]};
    end
    else if (push)
    begin
      pend_n_r  <= pend_n_r - 2'h1;
      pend_r[0] <= pend_r[1];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= 3'h0;
      rd_ptr_r <= 3'h0;
      count_r  <= 3'h0;
    end
    else if (soft_reset_state && dctrl_r[DC_MODE_LSB +: 3] == 3'h0)
    begin
      wr_ptr_r <= 3'h0;
      rd_ptr_r <= 3'h0;
      count_r  <= 3'h0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == 3'(RXQ_DEPTH - 1)) ? 3'h0 : wr_ptr_r + 3'h1;
      if (pop)
        rd_ptr_r <= (rd_ptr_r == 3'(RXQ_DEPTH - 1)) ? 3'h0 : rd_ptr_r + 3'h1;
      count_r <= count_r + {2'h0, push} - {2'h0, pop};
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (push)
      q_mem[wr_ptr_r] <= pend_r[0];
  end

  // ----------------------------------------------------------------
  // Host-written registers and commands
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hctrl_r    <= RST_HCTRL;
      cmd_vector <= '0;
      cmd_nmi    <= 1'b0;
    end
    else
    begin
      cmd_nmi <= 1'b0;
      if (data_ph && cmd_r == CMD_REG_WR && addr_r[3:0] == HREG_CTRL)
      begin
        hctrl_r[HC_FLAGS_LSB +: 3] <= s_ad[HC_FLAGS_LSB +: 3];
        // The format write is itself a burst, so only mode and queue work count
        if (dctrl_r[DC_MODE_LSB +: 3] == 3'h0 && pend_n_r == 2'h0)
          hctrl_r[3:0] <= s_ad[3:0];
      end
      if (data_ph && cmd_r == CMD_REG_WR && addr_r[3:0] == HREG_CVR)
      begin
        cmd_vector <= s_ad[VEC_W-1:0];
        cmd_nmi    <= s_ad[CV_NMI_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Core-side registers and interrupts
  // ----------------------------------------------------------------
  always_comb
  begin
    irq_set            = '0;
    irq_set[IRQ_HCMD]  = data_ph && cmd_r == CMD_REG_WR && addr_r[3:0] == HREG_CVR
                         && !s_ad[CV_NMI_BIT] && dctrl_r[DC_COMMAND_IRQ_ENABLE_BIT];
    irq_set[IRQ_RX]    = push;
    irq_set[IRQ_RETRY] = addr_ph && locked_r && !s_lock_n;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dctrl_r       <= RST_DCTRL;
      iae_r         <= 1'b0;
      master_format <= FMT_32;
      irq_msk_r     <= '0;
      irq_st_r      <= '0;
      tx_word_r     <= '0;
    end
    else
    begin
      if (reg_wr && reg_addr == CREG_CTRL)
        dctrl_r <= reg_wdata[7:0];
      if (reg_wr && reg_addr == CREG_PCTRL)
        iae_r <= reg_wdata[PC_IAE_BIT];
      if (reg_wr && reg_addr == CREG_MCTRL && soft_reset_state)
        master_format <= reg_wdata[MC_FC_LSB +: 2];
      if (reg_wr && reg_addr == CREG_IRQ_MSK)
        irq_msk_r <= reg_wdata[IRQ_W-1:0];
      if (reg_wr && reg_addr == CREG_TXWORD)
        tx_word_r <= reg_wdata[CORE_W-1:0];
      // Set wins over a same-cycle write-one clear
      irq_st_r <= (irq_st_r & ~((reg_wr && reg_addr == CREG_IRQ_ST) ? reg_wdata[IRQ_W-1:0] : '0)) | irq_set;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_valid_r <= 1'b0;
    else if (reg_wr && reg_addr == CREG_TXWORD)
      tx_valid_r <= 1'b1;
    else if (data_ph && cmd_r == CMD_MEM_RD)
      tx_valid_r <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0000_0000;
    else if (!reg_rd)
      reg_rdata <= 32'h0000_0000;
    else
      case (reg_addr)
        CREG_CTRL:    reg_rdata <= {24'h00_0000, dctrl_r};
        CREG_PCTRL:   reg_rdata <= {31'h0000_0000, iae_r};
        CREG_MCTRL:   reg_rdata <= {30'h0000_0000, master_format};
        CREG_STAT:    reg_rdata <= {26'h000_0000, locked_r, count_r != 3'h0,
                                    hctrl_r[HC_FLAGS_LSB +: 3], active};
        CREG_RXOUT:   reg_rdata <= {8'h00, q_mem[rd_ptr_r]};
        CREG_IRQ_ST:  reg_rdata <= {29'h0000_0000, irq_st_r};
        CREG_IRQ_MSK: reg_rdata <= {29'h0000_0000, irq_msk_r};
        CREG_CVR:     reg_rdata <= {25'h000_0000, cmd_vector};
        default:      reg_rdata <= 32'h0000_0000;
      endcase
  end

  assign core_irq      = |(irq_st_r & irq_msk_r);
  assign link.rdata    = rdata_r;
  assign link.retry    = retry_r;
  assign link.irq_n_o  = 1'b0;
  assign link.irq_n_oe = dctrl_r[DC_HOST_IRQ_SET_BIT_BIT];
endmodule : pci_port_dev

// ==== verilog/pci_port_host.sv ====
// Host end of the PCI host port: link clock, bursts, lock handling
`timescale 1ns/1ps
module pci_port_host (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  pci_link_if.host         link,
  input  wire logic        req_valid,
  input  wire logic [1:0]  req_cmd,
  input  wire logic [31:0] req_addr,
  input  wire logic [3:0]  req_len,
  input  wire logic        req_lock,
  input  wire logic [31:0] wr_data,
  output logic             req_ready,
  output logic             data_take,
  output logic [31:0]      rd_data,
  output logic             done,
  output logic             done_retry,
  output logic             host_irq
);
  import pci_port_pkg::*;

  typedef enum {S_IDLE, S_ADDR, S_DATA, S_LAST} host_state_t;

  host_state_t      state_r;
  logic [DIV_W-1:0] div_r;
  logic             pclk_r, rise_en, fall_en;
  logic             s_retry, s_irq_n, s_lock_n;
  logic [31:0]      s_rdata;
  logic [3:0]       left_r;
  logic             lock_r, retried_r;

  sync2 #(.W(35)) u_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .d     ({link.retry, link.irq_n, link.lock_n, link.rdata}),
    .init  ({3'b011, 32'h0000_0000}),
    .q     ({s_retry, s_irq_n, s_lock_n, s_rdata})
  );

  // ----------------------------------------------------------------
  // Link clock divider
  // ----------------------------------------------------------------
  assign rise_en = (div_r == DIV_W'(PCLK_HALF - 1)) && !pclk_r;
  assign fall_en = (div_r == DIV_W'(PCLK_HALF - 1)) && pclk_r;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_r  <= '0;
      pclk_r <= 1'b0;
    end
    else if (div_r == DIV_W'(PCLK_HALF - 1))
    begin
      div_r  <= '0;
      pclk_r <= ~pclk_r;
    end
    else
      div_r <= div_r + 1'b1;
  end

  // ----------------------------------------------------------------
  // Burst sequencer; link outputs change on falling link clock, read data taken on rising
  // ----------------------------------------------------------------
  assign req_ready = state_r == S_IDLE && fall_en && (!req_lock || s_lock_n);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r      <= S_IDLE;
      link.frame_n <= 1'b1;
      link.lock_n  <= 1'b1;
      link.cmd     <= CMD_REG_WR;
      link.ad      <= 32'h0000_0000;
      left_r       <= 4'h0;
      lock_r       <= 1'b0;
      retried_r    <= 1'b0;
      data_take    <= 1'b0;
      done         <= 1'b0;
      done_retry   <= 1'b0;
      rd_data      <= 32'h0000_0000;
    end
    else
    begin
      data_take <= 1'b0;
      done      <= 1'b0;
      case (state_r)
        S_IDLE:
          if (req_valid && req_ready)
          begin
            state_r      <= S_ADDR;
            link.frame_n <= 1'b0;
            link.lock_n  <= 1'b1;
            link.cmd     <= req_cmd;
            link.ad      <= req_addr;
            left_r       <= (req_len == 4'h0) ? 4'h1 : req_len;
            lock_r       <= req_lock;
            retried_r    <= 1'b0;
          end
        S_ADDR:
          if (fall_en)
          begin
            state_r     <= S_DATA;
            link.ad     <= wr_data;
            data_take   <= 1'b1;
            link.lock_n <= ~lock_r;
          end
        S_DATA:
          if (rise_en)
          begin
            rd_data <= s_rdata;
            if (s_retry || left_r == 4'h1)
            begin
              state_r   <= S_LAST;
              retried_r <= s_retry;
            end
            left_r <= left_r - 4'h1;
          end
          else if (fall_en && left_r != 4'h0)
          begin
            link.ad   <= wr_data;
            data_take <= 1'b1;
          end
        S_LAST:
          if (fall_en)
          begin
            state_r      <= S_IDLE;
            link.frame_n <= 1'b1;
            link.lock_n  <= 1'b1;
            done         <= 1'b1;
            done_retry   <= retried_r;
          end
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      host_irq <= 1'b0;
    else
      host_irq <= ~s_irq_n;
  end

  assign link.pclk = pclk_r;
endmodule : pci_port_host

// ==== tb/pci_port_props.sv ====
// Link checker for the PCI host port: lock, retry, read data and interrupt pin
`timescale 1ns/1ps
module pci_port_props (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        pclk,
  input wire logic        frame_n,
  input wire logic        lock_n,
  input wire logic [31:0] rdata,
  input wire logic        retry,
  input wire logic        irq_n_o,
  input wire logic        irq_n_oe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------------
  // Burst framing and interrupt pin
  // ------------------------------------------------------------------
  sequence s_burst_start;
    $fell(frame_n);
  endsequence
  sequence s_burst_end;
    $rose(frame_n);
  endsequence
  a_lock_free_addr: assert property (s_burst_start |-> lock_n) else $error("lock low in address");
  a_lock_released: assert property (s_burst_end |-> ##[0:24] lock_n) else $error("lock kept");
  a_lock_in_data: assert property ($fell(lock_n) |-> !frame_n) else $error("lock out of data");
  a_frame_on_fall: assert property ($changed(frame_n) |-> !pclk) else $error("frame moved");
  a_retry_in_burst: assert property ($rose(retry) |-> !frame_n) else $error("retry out of burst");
  a_retry_to_end: assert property ($fell(retry) |-> frame_n) else $error("retry dropped early");
  a_rdata_in_burst: assert property ($changed(rdata) |-> !frame_n) else $error("rdata moved");
  a_irq_drive_low: assert property (irq_n_oe |-> !irq_n_o) else $error("irq pin driven high");
endmodule : pci_port_props

// ==== tb/pci_host_port_control_flow_test.sv ====
// Testbench: host end and device end joined over the link
`timescale 1ns/1ps
module pci_host_port_control_flow_test;
  import pci_port_pkg::*;
  logic        core_clk, rst_n, reg_wr, reg_rd, req_valid, req_lock, r;
  logic        core_irq, cmd_nmi, req_ready, data_take, done, done_retry, host_irq;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, req_addr, wr_data, rd_data, v, d, a;
  logic [1:0]  req_cmd, master_format;
  logic [6:0]  cmd_vector, vec;
  logic [2:0]  hf, cf;
  int          seed, n_errors, n_checks, n_nmi;
  pci_link_if link_if();
  pci_port_dev pci_port_dev_inst (.core_clk, .rst_n, .link(link_if), .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .core_irq, .cmd_nmi, .cmd_vector, .master_format);
  pci_port_host pci_port_host_inst (.core_clk, .rst_n, .link(link_if), .req_valid, .req_cmd, .req_addr,
    .req_len(4'h1), .req_lock, .wr_data, .req_ready, .data_take, .rd_data, .done, .done_retry, .host_irq);
  pci_port_props pci_port_props_inst (.core_clk, .rst_n, .pclk(link_if.pclk), .frame_n(link_if.frame_n),
    .lock_n(link_if.lock_n), .rdata(link_if.rdata), .retry(link_if.retry), .irq_n_o(link_if.irq_n_o),
    .irq_n_oe(link_if.irq_n_oe));
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  initial
  begin
    core_clk = 0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (cmd_nmi === 1'b1) n_nmi++;
  function automatic logic [31:0] left_fmt(input logic [23:0] w);
    return {w, 8'h00};
  endfunction : left_fmt
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cwr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : cwr
  task automatic crd(input logic [7:0] ad, output logic [31:0] q);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : crd
  // Waits are bounded; a stuck handshake ends the run as a failure
  task automatic hx(input logic [1:0] c, input logic [31:0] ad, input logic [31:0] dt, input logic l,
                    output logic [31:0] q, output logic rt);
    int i;
    @(posedge core_clk);
    req_cmd <= c;
    req_addr <= ad;
    wr_data <= dt;
    req_lock <= l;
    req_valid <= 1'b1;
    @(negedge core_clk);
    for (i = 0; i < 200 && req_ready !== 1'b1; i++) @(negedge core_clk);
    @(posedge core_clk);
    req_valid <= 1'b0;
    for (i = 0; i < 200 && done !== 1'b1; i++) @(negedge core_clk);
    if (i == 200)
    begin
      n_errors++;
      summarize();
    end
    q = rd_data;
    rt = done_retry;
  endtask : hx
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    seed = 1126;
    {rst_n, reg_wr, reg_rd, req_valid, req_lock, req_cmd} = '0;
    {reg_addr, reg_wdata, req_addr, wr_data} = '0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    crd(CREG_CTRL, v); chk(v, {24'h0, RST_DCTRL});
    crd(CREG_STAT, v); chk(v, 32'h0000_0000);
    hx(CMD_REG_RD, {28'h0, HREG_STAT}, 0, 0, v, r); chk({31'h0, v[HS_PSR_BIT]}, 32'h0000_0001);
    hf = 3'($random(seed));
    hx(CMD_REG_WR, {28'h0, HREG_CTRL}, {25'h0, hf, 4'h9}, 0, v, r);
    crd(CREG_STAT, v); chk({29'h0, v[3:1]}, {29'h0, hf});
    cwr(CREG_PCTRL, 32'h0000_0001);
    cwr(CREG_IRQ_MSK, 32'h0000_0007);
    cf = 3'($random(seed));
    cwr(CREG_CTRL, {24'h0, 1'b1, cf, 4'h9});
    cwr(CREG_MCTRL, 32'h0000_0002);
    repeat (10) @(posedge core_clk);
    chk({31'h0, master_format == 2'h0}, 32'h0000_0001);
    chk({31'h0, host_irq}, 32'h0000_0001);
    chk({31'h0, link_if.irq_n}, 32'h0000_0000);
    hx(CMD_REG_RD, {28'h0, HREG_STAT}, 0, 1, v, r); chk({27'h0, v[4:0]}, {27'h0, 1'b0, cf, 1'b1});
    $display("test control and flags done");
    hx(CMD_REG_WR, {28'h0, HREG_CTRL}, 32'h0000_0000, 0, v, r);
    a = WINDOW_BASE + 32'(({$random(seed)} % WINDOW_WORDS) * 4);
    d = $random(seed);
    hx(CMD_MEM_WR, a, d, 1, v, r); chk({31'h0, r}, 32'h0000_0000);
    crd(CREG_RXOUT, v); chk(v, {8'h0, a[23:0]});
    crd(CREG_RXOUT, v); chk(v, {8'h0, d[23:0]});
    chk({31'h0, core_irq}, 32'h0000_0001);
    cwr(CREG_IRQ_ST, 32'h0000_0007);
    chk({31'h0, core_irq}, 32'h0000_0000);
    hx(CMD_MEM_WR, WINDOW_LIMIT, d, 0, v, r); chk({31'h0, r}, 32'h0000_0001);
    $display("test window writes done");
    vec = 7'($random(seed));
    hx(CMD_REG_WR, {28'h0, HREG_CVR}, {25'h0, vec}, 0, v, r);
    crd(CREG_IRQ_ST, v); chk(v, 32'h0000_0001);
    chk({25'h0, cmd_vector}, {25'h0, vec});
    cwr(CREG_IRQ_ST, 32'h0000_0001);
    cwr(CREG_IRQ_MSK, 32'h0000_0000);
    hx(CMD_REG_WR, {28'h0, HREG_CVR}, {24'h0, 1'b1, ~vec}, 0, v, r);
    chk(32'(n_nmi), 32'h0000_0001);
    crd(CREG_IRQ_ST, v); chk(v, 32'h0000_0000);
    chk({25'h0, cmd_vector}, {25'h0, ~vec});
    d = $random(seed);
    cwr(CREG_TXWORD, {8'h0, d[23:0]});
    hx(CMD_MEM_RD, WINDOW_BASE, 0, 0, v, r); chk(v, left_fmt(d[23:0]));
    $display("test commands and reads done");
    summarize();
  end
endmodule : pci_host_port_control_flow_test
